// [hw/pin_override_pkg.sv]
package pin_override_pkg;

    // port B bit positions
    localparam int SPI_CLOCK_BIT = 7;
    localparam int SPI_MISO_BIT = 6;
    localparam int SPI_MOSI_BIT = 5;
    localparam int SPI_SELECT_BIT = 4;
    localparam int COMPARE_A_BIT = 3;
    localparam int EXT_IRQ_BIT = 2;
    localparam int CLOCK_OUT_BIT = 1;
    localparam int USART_CLOCK_BIT = 0;

    // port C bit positions
    localparam int OSC_OUT_BIT = 7;
    localparam int OSC_IN_BIT = 6;
    localparam int TEST_DATA_IN_BIT = 5;
    localparam int TEST_DATA_OUT_BIT = 4;
    localparam int MODE_SELECT_BIT = 3;
    localparam int TEST_CLOCK_BIT = 2;
    localparam int TWO_WIRE_DATA_BIT = 1;
    localparam int TWO_WIRE_CLOCK_BIT = 0;

    // pin-change source numbering
    localparam int PORTB_CHANGE_BASE = 8;
    localparam int PORTC_CHANGE_BASE = 16;

    // reset values of the registered outputs
    localparam logic [7:0] PAD_CTRL_RESET = 8'h00;
    localparam logic PERIPH_IN_RESET = 1'h0;

    // forced override values
    localparam logic FORCED_INPUT = 1'h0;
    localparam logic FORCED_PULLUP = 1'h1;

endpackage

// [hw/pad_attr_resolve.sv]
`timescale 1ns/1ps
module pad_attr_resolve
    import pin_override_pkg::*;
(
    input wire logic [7:0] portValue,
    input wire logic [7:0] portDirection,
    input wire logic globalPullupDisable,
    input wire logic [7:0] pullupOverrideEn,
    input wire logic [7:0] pullupOverrideVal,
    input wire logic [7:0] dirOverrideEn,
    input wire logic [7:0] dirOverrideVal,
    input wire logic [7:0] outvalOverrideEn,
    input wire logic [7:0] outvalOverrideVal,
    input wire logic [7:0] inputBufOverrideEn,
    input wire logic [7:0] inputBufOverrideVal,
    input wire logic [7:0] padIn,
    output logic [7:0] pullupOn,
    output logic [7:0] driveEnable,
    output logic [7:0] driveValue,
    output logic [7:0] inputBufOn,
    output logic [7:0] digitalIn
);

    wire [7:0] normalPullup;

    // port pull-up only on an input pin with pull-ups globally allowed
    assign normalPullup = portValue & ~portDirection
        & {8{~globalPullupDisable}};

    // each attribute comes from its override when enabled
    assign pullupOn = (pullupOverrideEn & pullupOverrideVal)
        | (~pullupOverrideEn & normalPullup);
    assign driveEnable = (dirOverrideEn & dirOverrideVal)
        | (~dirOverrideEn & portDirection);
    assign driveValue = (outvalOverrideEn & outvalOverrideVal)
        | (~outvalOverrideEn & portValue);
    assign inputBufOn = (inputBufOverrideEn & inputBufOverrideVal)
        | ~inputBufOverrideEn;
    assign digitalIn = padIn & inputBufOn;

endmodule

// [hw/port_b_c_alt_function_override.sv]
// Behaviour
// - miso: master input, or slave output drive
// - mosi: master output drive, or slave input
// - spi pins qualified by enable and role
// - slave forces clock pin input, pull-up kept
// - interrupt-two pin keeps input buffer on
// - clock fuse drives divided clock on pin
// - usart clock pin direction bit chooses role
// - usart clock pin used only in synchronous mode
// - port b pins are change sources 8..15
// - port c pins are change sources 16..23
// - async timer frees oscillator output pin unless external clock input selected
// - async timer frees oscillator input pin
// - scan port owns test data input pin
// - test data output driven in shift states
// - scan port owns mode select and clock
// - two-wire enable sets data and clock output values, pins forced input
// - port c pins timer, scan, two-wire map
`timescale 1ns/1ps
module port_b_c_alt_function_override
    import pin_override_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] portbValue,
    input wire logic [7:0] portbDirection,
    input wire logic [7:0] portcValue,
    input wire logic [7:0] portcDirection,
    input wire logic globalPullupDisable,
    input wire logic [7:0] padbIn,
    input wire logic [7:0] padcIn,
    input wire logic spiOnBit,
    input wire logic spiMasterSelect,
    input wire logic spiClockOut,
    input wire logic spiMasterOut,
    input wire logic spiSlaveOut,
    input wire logic compareAEnable,
    input wire logic compareAValue,
    input wire logic compareBEnable,
    input wire logic compareBValue,
    input wire logic extIrqTwoEnable,
    input wire logic clockOutFuse,
    input wire logic dividedClock,
    input wire logic usartSyncMode,
    input wire logic usartClockOut,
    input wire logic [7:0] portbChangeMask,
    input wire logic portbChangeGroupEn,
    input wire logic [7:0] portcChangeMask,
    input wire logic portcChangeGroupEn,
    input wire logic timer2AsyncSelect,
    input wire logic extClockInputSelect,
    input wire logic scanPortOn,
    input wire logic shiftIr,
    input wire logic shiftDr,
    input wire logic testDataOut,
    input wire logic twoWireOn,
    input wire logic twoWireDataOut,
    input wire logic twoWireClockOut,
    output logic [7:0] padbPullup_q,
    output logic [7:0] padbDriveEnable_q,
    output logic [7:0] padbDriveValue_q,
    output logic [7:0] padbInputBuf_q,
    output logic [7:0] padcPullup_q,
    output logic [7:0] padcDriveEnable_q,
    output logic [7:0] padcDriveValue_q,
    output logic [7:0] padcInputBuf_q,
    output logic spiClockIn_q,
    output logic spiMasterIn_q,
    output logic spiSlaveIn_q,
    output logic spiSelectIn_q,
    output logic extIrqTwoIn_q,
    output logic timer0CountIn_q,
    output logic timer1CountIn_q,
    output logic usartClockIn_q,
    output logic testDataIn_q,
    output logic testModeSelect_q,
    output logic testClock_q,
    output logic twoWireDataIn_q,
    output logic twoWireClockIn_q,
    output logic [15:0] changeSource_q
);

    function automatic logic [7:0] changeEnables(
        input logic [7:0] mask,
        input logic groupEn
    );
        changeEnables = mask & {8{groupEn}};
    endfunction

    wire spiSlave;
    wire spiMaster;
    wire usartClockDrive;
    wire oscOutTaken;
    wire [7:0] bChange;
    wire [7:0] cChange;
    wire [7:0] bPuEn, bPuVal, bDirEn, bDirVal, bOutEn, bOutVal;
    wire [7:0] bInEn, bInVal;
    wire [7:0] cPuEn, cPuVal, cDirEn, cDirVal, cOutEn, cOutVal;
    wire [7:0] cInEn, cInVal;
    wire [7:0] bPullup, bDrive, bValue, bBuf, bDigital;
    wire [7:0] cPullup, cDrive, cValue, cBuf, cDigital;
    wire [7:0] bPortPull;
    wire [7:0] cPortPull;

    assign spiSlave = spiOnBit & ~spiMasterSelect;
    assign spiMaster = spiOnBit & spiMasterSelect;
    assign usartClockDrive = usartSyncMode
        & portbDirection[USART_CLOCK_BIT];
    assign oscOutTaken = timer2AsyncSelect & ~extClockInputSelect;
    assign bChange = changeEnables(portbChangeMask,
        portbChangeGroupEn);
    assign cChange = changeEnables(portcChangeMask,
        portcChangeGroupEn);
    assign bPortPull = portbValue & {8{~globalPullupDisable}};
    assign cPortPull = portcValue & {8{~globalPullupDisable}};

    // port B: spi pins forced to input in the receiving role
    assign bPuEn[7:4] = {spiSlave, spiMaster, spiSlave, spiSlave};
    assign bDirEn[7:4] = bPuEn[7:4];
    assign bPuVal[7:4] = bPortPull[7:4];
    assign bDirVal[7:4] = {4{FORCED_INPUT}};
    assign bOutEn[SPI_CLOCK_BIT] = spiMaster;
    assign bOutVal[SPI_CLOCK_BIT] = spiClockOut;
    assign bOutEn[SPI_MISO_BIT] = spiSlave;
    assign bOutVal[SPI_MISO_BIT] = spiSlaveOut;
    assign bOutEn[SPI_MOSI_BIT] = spiMaster;
    assign bOutVal[SPI_MOSI_BIT] = spiMasterOut;
    assign bOutEn[SPI_SELECT_BIT] = compareBEnable;
    assign bOutVal[SPI_SELECT_BIT] = compareBValue;
    assign bOutEn[COMPARE_A_BIT] = compareAEnable;
    assign bOutVal[COMPARE_A_BIT] = compareAValue;
    assign bPuEn[3:0] = 4'h0;
    assign bPuVal[3:0] = 4'h0;
    assign bDirEn[3:0] = {2'h0, clockOutFuse, 1'h0};
    assign bDirVal[3:0] = {2'h0, clockOutFuse, 1'h0};
    assign bOutEn[EXT_IRQ_BIT] = 1'h0;
    assign bOutVal[EXT_IRQ_BIT] = 1'h0;
    assign bOutEn[CLOCK_OUT_BIT] = clockOutFuse;
    assign bOutVal[CLOCK_OUT_BIT] = dividedClock;
    assign bOutEn[USART_CLOCK_BIT] = usartClockDrive;
    assign bOutVal[USART_CLOCK_BIT] = usartClockOut;
    assign bInEn = bChange
        | ({7'h00, extIrqTwoEnable} << EXT_IRQ_BIT);
    assign bInVal = 8'hFF;

    // port C: timer oscillator, scan port, two-wire bus
    assign cPuEn = {oscOutTaken, timer2AsyncSelect, {4{scanPortOn}},
        {2{twoWireOn}}};
    assign cPuVal = {2'h0, {4{FORCED_PULLUP}},
        cPortPull[1:0]};
    assign cDirEn = cPuEn;
    assign cDirVal = {3'h0, shiftIr | shiftDr, 4'h0};
    assign cOutEn = {3'h0, scanPortOn, 2'h0, {2{twoWireOn}}};
    assign cOutVal = {3'h0, testDataOut, 2'h0, twoWireDataOut,
        twoWireClockOut};
    assign cInEn = cChange | {oscOutTaken, timer2AsyncSelect,
        {4{scanPortOn}}, 2'h0};
    assign cInVal = {~oscOutTaken,
        extClockInputSelect | ~timer2AsyncSelect,
        {4{~scanPortOn}}, 2'h3};

    pad_attr_resolve portbResolve (
        .portValue(portbValue),
        .portDirection(portbDirection),
        .globalPullupDisable(globalPullupDisable),
        .pullupOverrideEn(bPuEn),
        .pullupOverrideVal(bPuVal),
        .dirOverrideEn(bDirEn),
        .dirOverrideVal(bDirVal),
        .outvalOverrideEn(bOutEn),
        .outvalOverrideVal(bOutVal),
        .inputBufOverrideEn(bInEn),
        .inputBufOverrideVal(bInVal),
        .padIn(padbIn),
        .pullupOn(bPullup),
        .driveEnable(bDrive),
        .driveValue(bValue),
        .inputBufOn(bBuf),
        .digitalIn(bDigital)
    );

    pad_attr_resolve portcResolve (
        .portValue(portcValue),
        .portDirection(portcDirection),
        .globalPullupDisable(globalPullupDisable),
        .pullupOverrideEn(cPuEn),
        .pullupOverrideVal(cPuVal),
        .dirOverrideEn(cDirEn),
        .dirOverrideVal(cDirVal),
        .outvalOverrideEn(cOutEn),
        .outvalOverrideVal(cOutVal),
        .inputBufOverrideEn(cInEn),
        .inputBufOverrideVal(cInVal),
        .padIn(padcIn),
        .pullupOn(cPullup),
        .driveEnable(cDrive),
        .driveValue(cValue),
        .inputBufOn(cBuf),
        .digitalIn(cDigital)
    );

    // peripheral inputs taken from the pads
    wire spiClockIn_d, spiMasterIn_d, spiSlaveIn_d, spiSelectIn_d;
    wire usartClockIn_d;
    assign spiClockIn_d = spiSlave & bDigital[SPI_CLOCK_BIT];
    assign spiMasterIn_d = spiMaster & bDigital[SPI_MISO_BIT];
    assign spiSlaveIn_d = spiSlave & bDigital[SPI_MOSI_BIT];
    // idle high unless a slave sees its select
    assign spiSelectIn_d = ~spiSlave | bDigital[SPI_SELECT_BIT];
    assign usartClockIn_d = usartSyncMode
        & ~portbDirection[USART_CLOCK_BIT]
        & bDigital[USART_CLOCK_BIT];

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            padbPullup_q <= PAD_CTRL_RESET;
            padbDriveEnable_q <= PAD_CTRL_RESET;
            padbDriveValue_q <= PAD_CTRL_RESET;
            padbInputBuf_q <= PAD_CTRL_RESET;
            padcPullup_q <= PAD_CTRL_RESET;
            padcDriveEnable_q <= PAD_CTRL_RESET;
            padcDriveValue_q <= PAD_CTRL_RESET;
            padcInputBuf_q <= PAD_CTRL_RESET;
        end else begin
            padbPullup_q <= bPullup;
            padbDriveEnable_q <= bDrive;
            padbDriveValue_q <= bValue;
            padbInputBuf_q <= bBuf;
            padcPullup_q <= cPullup;
            padcDriveEnable_q <= cDrive;
            padcDriveValue_q <= cValue;
            padcInputBuf_q <= cBuf;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            spiClockIn_q <= PERIPH_IN_RESET;
            spiMasterIn_q <= PERIPH_IN_RESET;
            spiSlaveIn_q <= PERIPH_IN_RESET;
            spiSelectIn_q <= PERIPH_IN_RESET;
            extIrqTwoIn_q <= PERIPH_IN_RESET;
            timer0CountIn_q <= PERIPH_IN_RESET;
            timer1CountIn_q <= PERIPH_IN_RESET;
            usartClockIn_q <= PERIPH_IN_RESET;
        end else begin
            spiClockIn_q <= spiClockIn_d;
            spiMasterIn_q <= spiMasterIn_d;
            spiSlaveIn_q <= spiSlaveIn_d;
            spiSelectIn_q <= spiSelectIn_d;
            extIrqTwoIn_q <= bDigital[EXT_IRQ_BIT];
            timer0CountIn_q <= bDigital[USART_CLOCK_BIT];
            timer1CountIn_q <= bDigital[CLOCK_OUT_BIT];
            usartClockIn_q <= usartClockIn_d;
        end
    end

    // scan pins read through the analogue path, buffer is off
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            testDataIn_q <= PERIPH_IN_RESET;
            testModeSelect_q <= PERIPH_IN_RESET;
            testClock_q <= PERIPH_IN_RESET;
            twoWireDataIn_q <= PERIPH_IN_RESET;
            twoWireClockIn_q <= PERIPH_IN_RESET;
        end else begin
            testDataIn_q <= scanPortOn & padcIn[TEST_DATA_IN_BIT];
            testModeSelect_q <= scanPortOn & padcIn[MODE_SELECT_BIT];
            testClock_q <= scanPortOn & padcIn[TEST_CLOCK_BIT];
            twoWireDataIn_q <= padcIn[TWO_WIRE_DATA_BIT];
            twoWireClockIn_q <= padcIn[TWO_WIRE_CLOCK_BIT];
        end
    end

    // pin-change sources: port B low byte, port C high byte
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_change
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    changeSource_q[i] <= PERIPH_IN_RESET;
                    changeSource_q[i + 8] <= PERIPH_IN_RESET;
                end else begin
                    changeSource_q[i] <= bDigital[i];
                    changeSource_q[i + 8] <= cDigital[i];
                end
            end
        end
    endgenerate

    // checks wait one edge after release, outputs still hold reset values
    logic checkArmed_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            checkArmed_q <= PERIPH_IN_RESET;
        end else begin
            checkArmed_q <= 1'h1;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n || !checkArmed_q);

    chk_slave_clock_input: assert property (
        spiSlave |=> !padbDriveEnable_q[SPI_CLOCK_BIT]
            && padbPullup_q[SPI_CLOCK_BIT]
            == $past(portbValue[SPI_CLOCK_BIT] & ~globalPullupDisable))
        else $error("slave clock pin not forced input");

    chk_miso_slave_drive: assert property (
        spiSlave |=> padbDriveValue_q[SPI_MISO_BIT] == $past(spiSlaveOut))
        else $error("miso not driven from slave output");

    chk_mosi_master_drive: assert property (
        spiMaster |=> padbDriveValue_q[SPI_MOSI_BIT] == $past(spiMasterOut)
            && !padbDriveEnable_q[SPI_MISO_BIT])
        else $error("mosi or miso wrong in master role");

    chk_clock_fuse_out: assert property (
        clockOutFuse |=> padbDriveEnable_q[CLOCK_OUT_BIT]
            && padbDriveValue_q[CLOCK_OUT_BIT] == $past(dividedClock))
        else $error("divided clock not on pin");

    chk_irq_two_buffer: assert property (
        extIrqTwoEnable |=> padbInputBuf_q[EXT_IRQ_BIT]
            && extIrqTwoIn_q == $past(padbIn[EXT_IRQ_BIT]))
        else $error("interrupt two input lost");

    chk_usart_clock_gate: assert property (
        !usartSyncMode |=> !usartClockIn_q)
        else $error("usart clock seen outside sync mode");

    chk_change_b_source: assert property (
        (portbChangeMask[0] && portbChangeGroupEn)
            |=> changeSource_q[0] == $past(padbIn[0]))
        else $error("port b change source wrong");

    chk_osc_out_free: assert property (
        oscOutTaken |=> !padcPullup_q[OSC_OUT_BIT]
            && !padcDriveEnable_q[OSC_OUT_BIT]
            && !padcInputBuf_q[OSC_OUT_BIT])
        else $error("oscillator output pin not freed");

    chk_scan_tdo_shift: assert property (
        (scanPortOn && !shiftIr && !shiftDr)
            |=> !padcDriveEnable_q[TEST_DATA_OUT_BIT]
            && padcPullup_q[TEST_DATA_OUT_BIT])
        else $error("test data output driven outside shift");

    chk_scan_tdi_pin: assert property (
        scanPortOn |=> !padcInputBuf_q[TEST_DATA_IN_BIT]
            && testDataIn_q == $past(padcIn[TEST_DATA_IN_BIT]))
        else $error("test data input pin wrong");

    chk_two_wire_drive: assert property (
        twoWireOn |=> padcDriveValue_q[1:0]
            == $past({twoWireDataOut, twoWireClockOut})
            && padcDriveEnable_q[1:0] == 2'h0)
        else $error("two-wire pins not driven from bus");

endmodule

// [verification/pad_board_model.sv]
`timescale 1ns/1ps
module pad_board_model (
    input wire logic clock,
    input wire logic [7:0] driveEnable,
    input wire logic [7:0] driveValue,
    input wire logic [7:0] pullupOn,
    input wire logic [7:0] boardEnable,
    input wire logic [7:0] boardLevel,
    output logic [7:0] pad
);
    // a floating pad changes every cycle so that a stale value never passes
    logic [7:0] floatPattern = 8'h55;

    always @(posedge clock) begin
        floatPattern <= ~floatPattern;
    end

    // device driver first, then the board, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (driveEnable[i]) begin
                pad[i] = driveValue[i];
            end else if (boardEnable[i]) begin
                pad[i] = boardLevel[i];
            end else if (pullupOn[i]) begin
                pad[i] = 1'h1;
            end else begin
                pad[i] = floatPattern[i];
            end
        end
    end
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
module tb
    import pin_override_pkg::*;
();
    typedef struct packed {
        logic [23:0] ctl;
        logic [31:0] portSet;
        logic [63:0] expAttr;
    } row_type;

    logic clock;
    logic arst_n;
    logic [23:0] ctl;
    logic [7:0] bv, bd, cv, cd, mb, mc;
    logic gb, gc;
    logic [7:0] boardEnB, boardLvB, boardEnC, boardLvC, padb, padc;
    logic [7:0] puB, deB, dvB, ibB, puC, deC, dvC, ibC;
    logic spiClkIn, misoIn, mosiIn, selIn, irqIn, t0In, t1In, usartIn;
    logic tdiIn, tmsIn, tckIn, sdaIn, sclIn;
    logic [15:0] chg;
    logic [63:0] attr;
    int numErrors = 0;
    int checkCount = 0;

    // control word: spi 4..0, timer0 compare 8..5, irq 9, clock out 11..10,
    // usart 13..12, timer2 15..14, scan 19..16, two-wire 22..20, pud 23
    row_type rows [13] = '{
        '{24'h000000, 32'hA50F3CC3, 64'hA00FA5FF3CC33CFF},
        '{24'h800000, 32'hA50F3CC3, 64'h000FA5FF00C33CFF},
        '{24'h000011, 32'hB0FF0000, 64'hB04FF0FF000000FF},
        '{24'h00001B, 32'hFFFF0000, 64'h40BF7FFF000000FF},
        '{24'h003CE0, 32'h10190000, 64'h001B0BFF000000FF},
        '{24'h002CE0, 32'h10190000, 64'h001B0AFF000000FF},
        '{24'h004000, 32'h0000C000, 64'h000000FF0000C03F},
        '{24'h00C000, 32'h0000C000, 64'h000000FF8000C0FF},
        '{24'h0B0000, 32'h0000003C, 64'h000000FF3C1010C3},
        '{24'h050000, 32'h0000003C, 64'h000000FF3C1000C3},
        '{24'h010000, 32'h0000003C, 64'h000000FF3C0000C3},
        '{24'h300000, 32'h00000303, 64'h000000FF030002FF},
        '{24'hB00000, 32'h00000303, 64'h000000FF000002FF}
    };

    assign attr = {puB, deB, dvB, ibB, puC, deC, dvC, ibC};

    port_b_c_alt_function_override i_dut (
        .clock(clock), .arst_n(arst_n),
        .portbValue(bv), .portbDirection(bd),
        .portcValue(cv), .portcDirection(cd),
        .globalPullupDisable(ctl[23]), .padbIn(padb), .padcIn(padc),
        .spiOnBit(ctl[0]), .spiMasterSelect(ctl[1]),
        .spiClockOut(ctl[2]), .spiMasterOut(ctl[3]), .spiSlaveOut(ctl[4]),
        .compareAEnable(ctl[5]), .compareAValue(ctl[6]),
        .compareBEnable(ctl[7]), .compareBValue(ctl[8]),
        .extIrqTwoEnable(ctl[9]), .clockOutFuse(ctl[10]),
        .dividedClock(ctl[11]), .usartSyncMode(ctl[12]),
        .usartClockOut(ctl[13]),
        .portbChangeMask(mb), .portbChangeGroupEn(gb),
        .portcChangeMask(mc), .portcChangeGroupEn(gc),
        .timer2AsyncSelect(ctl[14]), .extClockInputSelect(ctl[15]),
        .scanPortOn(ctl[16]), .shiftIr(ctl[17]), .shiftDr(ctl[18]),
        .testDataOut(ctl[19]), .twoWireOn(ctl[20]),
        .twoWireDataOut(ctl[21]), .twoWireClockOut(ctl[22]),
        .padbPullup_q(puB), .padbDriveEnable_q(deB),
        .padbDriveValue_q(dvB), .padbInputBuf_q(ibB),
        .padcPullup_q(puC), .padcDriveEnable_q(deC),
        .padcDriveValue_q(dvC), .padcInputBuf_q(ibC),
        .spiClockIn_q(spiClkIn), .spiMasterIn_q(misoIn),
        .spiSlaveIn_q(mosiIn), .spiSelectIn_q(selIn),
        .extIrqTwoIn_q(irqIn), .timer0CountIn_q(t0In),
        .timer1CountIn_q(t1In), .usartClockIn_q(usartIn),
        .testDataIn_q(tdiIn), .testModeSelect_q(tmsIn),
        .testClock_q(tckIn), .twoWireDataIn_q(sdaIn),
        .twoWireClockIn_q(sclIn), .changeSource_q(chg)
    );

    pad_board_model i_board_b (
        .clock(clock), .driveEnable(deB), .driveValue(dvB),
        .pullupOn(puB), .boardEnable(boardEnB), .boardLevel(boardLvB),
        .pad(padb)
    );

    pad_board_model i_board_c (
        .clock(clock), .driveEnable(deC), .driveValue(dvC),
        .pullupOn(puC), .boardEnable(boardEnC), .boardLevel(boardLvC),
        .pad(padc)
    );

    task automatic check(input logic [63:0] got, input logic [63:0] want,
                         input string what);
        checkCount++;
        if (got !== want) begin
            numErrors++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what,
                     got, want);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    // the whole sequence needs well under 200 cycles
    initial begin
        repeat (3000) @(posedge clock);
        numErrors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        print_verdict();
    end

    initial begin
        arst_n = 1'h0;
        ctl = 24'h0;
        {bv, bd, cv, cd, mb, mc, gb, gc} = 50'h0;
        {boardEnB, boardLvB, boardEnC, boardLvC} = 32'h0;
        settle(19);
        check(attr, {8{PAD_CTRL_RESET}}, "startup reset");
        @(posedge clock);
        arst_n <= 1'h1;
        foreach (rows[i]) begin
            @(posedge clock);
            ctl <= rows[i].ctl;
            {bv, bd, cv, cd} <= rows[i].portSet;
            settle(1);
            check(attr, rows[i].expAttr, "table row");
        end
        // one edge of latency exactly
        @(posedge clock);
        bv <= 8'h5A;
        #1;
        check(dvB, 8'h00, "before edge");
        settle(1);
        check(dvB, 8'h5A, "after edge");
        // slave role, board master pulls select low
        @(posedge clock);
        ctl <= 24'h000011;
        {bv, bd, cv, cd} <= 32'h00400000;
        {boardEnB, boardLvB} <= 16'hB0A0;
        settle(3);
        check({spiClkIn, misoIn, mosiIn, selIn, padb[6]}, 5'h15, "slave");
        // master role, board answers on the master input
        @(posedge clock);
        ctl <= 24'h00000F;
        bd <= 8'hA0;
        {boardEnB, boardLvB} <= 16'h5040;
        settle(3);
        check({spiClkIn, misoIn, mosiIn, selIn, padb[7], padb[5]}, 6'h17,
              "master");
        // change sources with the oscillator pins taken
        @(posedge clock);
        ctl <= 24'h004200;
        {bv, bd, cv, cd} <= 32'h0;
        {gb, gc, mb, mc} <= {2'h3, 16'hFFFF};
        {boardEnB, boardLvB, boardEnC, boardLvC} <= 32'hFF96FFC5;
        settle(3);
        check(chg, 16'h0596, "change sources");
        check({irqIn, t0In, t1In, sdaIn, sclIn}, 5'h15, "pad inputs");
        // scan port inputs and the usart clock input
        @(posedge clock);
        ctl <= 24'h011000;
        {gb, gc} <= 2'h0;
        {boardEnB, boardLvB, boardEnC, boardLvC} <= 32'hFF01EF28;
        settle(3);
        check({tdiIn, tmsIn, tckIn, usartIn}, 4'hD, "scan inputs");
        // reset in mid-run clears at once, first edge after reloads
        @(posedge clock);
        arst_n <= 1'h0;
        #1;
        check(attr, {8{PAD_CTRL_RESET}}, "mid-run reset");
        check({chg, selIn}, 17'h0, "mid-run reset inputs");
        settle(2);
        @(posedge clock);
        arst_n <= 1'h1;
        settle(1);
        check(ibC, 8'hC3, "first edge after reset");
        print_verdict();
    end
endmodule
